// [src/mlss_core.sv]
// file: word fifo and the master-list / slave-status block engine
`timescale 1ns/1ps
`default_nettype none

// =======================================================================
// fifo with registered output stage
module mlss_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  // fill side
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  // drain side
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0]  wp;
    logic [AW-1:0]  rp;
    logic [AW:0]    cnt;
    logic           ov;
    logic [WIDTH-1:0] od;
  } mlss_fifo_s;

  mlss_fifo_s       s_r;
  mlss_fifo_s       s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // full is honest: count of stored words reaches depth
  assign o_ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign o_valid = s_r.ov;
  assign o_data  = s_r.od;
  assign push    = i_valid && o_ready;
  assign pop     = (!s_r.ov || i_ready) && (s_r.cnt != '0);

  // pointer and output stage update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
      s_nxt.ov = 1'b1;
      s_nxt.od = mem[s_r.rp];
    end else if (i_ready) begin
      s_nxt.ov = 1'b0;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // storage carries no reset
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[s_r.wp] <= i_data;
    end
  end
endmodule // mlss_fifo

// =======================================================================
// block engine
module mlss_core (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // restart and configuration
  input  wire logic        i_restart,
  input  wire logic [15:0] i_suspend_scans,
  // write blocks from host, one word per beat, 64 words per block
  input  wire logic        i_wb_valid,
  input  wire logic [15:0] i_wb_word,
  output logic             o_wb_ready,
  // read blocks to host (module_to_host_transfer)
  output logic             o_rd_valid,
  output logic [15:0]      o_rd_word,
  output logic             o_rd_last,
  input  wire logic        i_rd_ready,
  // list scan from the port engine
  input  wire logic        i_scan_valid,
  input  wire logic        i_scan_port,
  input  wire logic [6:0]  i_scan_cmd,
  output logic             o_scan_done,
  output logic             o_scan_allow,
  // retry exhaustion from the port engine
  input  wire logic        i_fail_valid,
  input  wire logic        i_fail_port,
  input  wire logic [7:0]  i_fail_node,
  // status
  output logic             o_load_done
);
  typedef struct packed {
    mlss_pkg::mlss_st_e   st;
    mlss_pkg::mlss_kind_e kind;
    logic                 port;
    logic [15:0]          code;
    logic [4:0]           blk;
    logic [2:0]           grp;
    logic [15:0]          cnt;
    logic [6:0]           proc;
    logic [2:0]           cmd;
    logic [3:0]           off;
    logic [5:0]           widx;
    logic [8:0]           clr;
    logic                 loading;
    logic                 lport;
    logic [4:0]           lblk;
    logic                 rdy;
    logic                 sdone;
    logic                 sallow;
    logic                 ldone;
  } mlss_core_s;
  mlss_core_s  s_r;
  mlss_core_s  s_nxt;
  logic [1:0]  state_mem [512];
  logic [15:0] dly_mem   [512];
  logic [7:0]  node_mem  [200];
  mlss_pkg::mlss_word_s ow;
  mlss_pkg::mlss_word_s fw;
  logic        push, f_ready, take, in_list, slot, wr_node, wr_slv;
  logic [15:0] rel, lbase, cbase, sdly;
  logic [8:0]  gidx, sidx;
  logic [7:0]  nidx;
  logic [1:0]  sst, wr_val;

  assign take = i_wb_valid && s_r.rdy;

  // =====================================================================
  // scan lookup: node of the scanned command and that slave's state
  assign nidx = 8'(({1'b0, i_scan_cmd}) + (i_scan_port ?
                mlss_pkg::CMDS_PER_PRT : 8'h00));
  assign sidx = {i_scan_port, node_mem[nidx]};
  assign sst  = state_mem[sidx];
  assign sdly = dly_mem[sidx];
  // =====================================================================
  // outgoing word: requests and replies share one generator
  always_comb begin
    gidx = 9'(s_r.grp * mlss_pkg::GROUP_SIZE) + 9'(s_r.widx)
           - 9'(mlss_pkg::FIRST_DATA);
    ow.last = (s_r.widx == mlss_pkg::LAST_WORD);
    ow.data = 16'h0000;
    if (s_r.kind == mlss_pkg::K_REQ) begin
      if (s_r.widx == 6'h00) begin
        ow.data = mlss_pkg::REQ_MARK;
      end else if (s_r.widx == 6'h01) begin
        ow.data = s_r.code;
      end
    end else if (s_r.widx <= 6'h01) begin
      ow.data = s_r.code;
    end else if (s_r.kind == mlss_pkg::K_STAT) begin
      if (s_r.widx <= mlss_pkg::LAST_DATA && gidx < 9'h100) begin
        ow.data = {14'h0000, state_mem[{s_r.port, gidx[7:0]}]};
      end
    end else if (s_r.widx == mlss_pkg::FIRST_DATA) begin
      ow.data = {9'h000, s_r.proc};
    end
  end
  assign push = (s_r.st == mlss_pkg::ST_EMIT);
  // =====================================================================
  // word-zero decode of an incoming block, code alone decides its kind
  always_comb begin
    in_list = (i_wb_word >= mlss_pkg::LIST_BASE_P2) &&
              (i_wb_word < mlss_pkg::LIST_BASE_P2 + mlss_pkg::LIST_BLOCKS);
    lbase = in_list ? mlss_pkg::LIST_BASE_P2 : mlss_pkg::LIST_BASE_P1;
    cbase = (i_wb_word >= mlss_pkg::CTL_BASE_P2) ?
            mlss_pkg::CTL_BASE_P2 : mlss_pkg::CTL_BASE_P1;
    rel   = i_wb_word - cbase;
  end
  // =====================================================================
  // table write decode for the current write word
  always_comb begin
    slot    = (s_r.widx >= mlss_pkg::FIRST_DATA) &&
              (s_r.widx <= mlss_pkg::LAST_DATA) &&
              (16'(s_r.widx - mlss_pkg::FIRST_DATA) < s_r.cnt);
    wr_node = take && s_r.kind == mlss_pkg::K_LIST && s_r.widx != 6'h00 &&
              s_r.widx <= mlss_pkg::LAST_CMDW &&
              s_r.off == mlss_pkg::CMD_NODE_OFF;
    wr_slv  = take && slot && i_wb_word[15:8] == 8'h00 &&
              (s_r.kind == mlss_pkg::K_DIS ||
               s_r.kind == mlss_pkg::K_ENA);
    wr_val  = (s_r.kind == mlss_pkg::K_DIS) ? mlss_pkg::SLV_DISABLED
                                            : mlss_pkg::SLV_ACTIVE;
  end
  // =====================================================================
  // main sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.sdone  = i_scan_valid;
    // suspended slave reaching zero is polled again on this very scan
    s_nxt.sallow = i_scan_valid && (sst == mlss_pkg::SLV_ACTIVE ||
                   (sst == mlss_pkg::SLV_SUSP && sdly <= 16'h0001));
    case (s_r.st)
      mlss_pkg::ST_CLR: begin
        s_nxt.clr = s_r.clr + 1'b1;
        if (s_r.clr == mlss_pkg::CLR_LAST) begin
          s_nxt.st   = mlss_pkg::ST_EMIT;
          s_nxt.kind = mlss_pkg::K_REQ;
          s_nxt.code = mlss_pkg::LIST_BASE_P1;
          s_nxt.widx = 6'h00;
        end
      end
      mlss_pkg::ST_EMIT: begin
        if (f_ready) begin
          s_nxt.widx = s_r.widx + 1'b1;
          if (ow.last) begin
            s_nxt.widx = 6'h00;
            if (s_r.kind != mlss_pkg::K_REQ && s_r.loading) begin
              // reply done during loading: poll again for the pending block
              s_nxt.kind = mlss_pkg::K_REQ;
              s_nxt.code = (s_r.lport ? mlss_pkg::LIST_BASE_P2
                           : mlss_pkg::LIST_BASE_P1) + 16'(s_r.lblk);
            end else begin
              s_nxt.st  = mlss_pkg::ST_RECV;
              s_nxt.rdy = 1'b1;
            end
          end
        end
      end
      mlss_pkg::ST_RECV: begin
        if (take) begin
          s_nxt.widx = s_r.widx + 1'b1;
          if (s_r.widx == 6'h00) begin
            s_nxt.code = i_wb_word;
            s_nxt.kind = mlss_pkg::K_NONE;
            s_nxt.cnt  = 16'h0000;
            s_nxt.proc = 7'h00;
            s_nxt.cmd  = 3'h0;
            s_nxt.off  = 4'h0;
            s_nxt.port = (i_wb_word >= mlss_pkg::CTL_BASE_P2);
            s_nxt.grp  = 3'(rel - mlss_pkg::OFF_STAT_LO);
            if (i_wb_word >= lbase &&
                i_wb_word < lbase + mlss_pkg::LIST_BLOCKS) begin
              s_nxt.kind = mlss_pkg::K_LIST;
              s_nxt.port = in_list;
              s_nxt.blk  = 5'(i_wb_word - lbase);
            end else if (i_wb_word == cbase) begin
              s_nxt.kind = mlss_pkg::K_DIS;
            end else if (rel == mlss_pkg::OFF_ENA) begin
              s_nxt.kind = mlss_pkg::K_ENA;
            end else if (rel >= mlss_pkg::OFF_STAT_LO &&
                         rel <= mlss_pkg::OFF_STAT_HI) begin
              s_nxt.kind = mlss_pkg::K_STAT;
            end
          end else if (s_r.widx == 6'h01) begin
            s_nxt.cnt = i_wb_word;
            s_nxt.off = 4'h1; // next list word is offset one
          end else if (s_r.kind == mlss_pkg::K_LIST) begin
            // walk five twelve-word command definitions
            s_nxt.off = s_r.off + 1'b1;
            if (s_r.off == mlss_pkg::CMD_LAST_OFF) begin
              s_nxt.off = 4'h0;
              s_nxt.cmd = s_r.cmd + 1'b1;
            end
          end
          if (wr_slv) begin
            s_nxt.proc = s_r.proc + 1'b1;
          end
          if (s_r.widx == mlss_pkg::LAST_WORD) begin
            s_nxt.widx = 6'h00;
            // expected list block arrived: step to the next one in order
            if (s_r.loading && s_r.kind == mlss_pkg::K_LIST &&
                s_r.port == s_r.lport && s_r.blk == s_r.lblk) begin
              s_nxt.lblk = s_r.lblk + 1'b1;
              if (s_r.lblk == mlss_pkg::LAST_BLK) begin
                s_nxt.lblk  = 5'h00;
                s_nxt.lport = 1'b1;
                if (s_r.lport) begin
                  s_nxt.loading = 1'b0;
                  s_nxt.ldone   = 1'b1;
                end
              end
            end
            if (s_r.kind == mlss_pkg::K_STAT || s_r.kind == mlss_pkg::K_DIS ||
                s_r.kind == mlss_pkg::K_ENA) begin
              s_nxt.st  = mlss_pkg::ST_EMIT;
              s_nxt.rdy = 1'b0;
            end else if (s_nxt.loading) begin
              s_nxt.st   = mlss_pkg::ST_EMIT;
              s_nxt.rdy  = 1'b0;
              s_nxt.kind = mlss_pkg::K_REQ;
              s_nxt.code = (s_nxt.lport ? mlss_pkg::LIST_BASE_P2
                           : mlss_pkg::LIST_BASE_P1) + 16'(s_nxt.lblk);
            end
          end
        end
      end
      default: begin
        s_nxt.st = mlss_pkg::ST_CLR;
      end
    endcase
    if (i_restart) begin
      s_nxt = '0;
      s_nxt.loading = 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_r <= '0;
      s_r.loading <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  // =====================================================================
  // slave tables; later writes win, host override has the last word
  always_ff @(posedge i_ref_clk) begin
    if (s_r.st == mlss_pkg::ST_CLR) begin
      state_mem[s_r.clr] <= mlss_pkg::SLV_UNDEF;
    end
    if (i_scan_valid && sst == mlss_pkg::SLV_SUSP) begin
      dly_mem[sidx] <= sdly - 16'h0001;
      if (sdly <= 16'h0001) begin
        state_mem[sidx] <= mlss_pkg::SLV_ACTIVE;
      end
    end
    // a disabled slave ignores failures and stays silent
    if (i_fail_valid &&
        state_mem[{i_fail_port, i_fail_node}] == mlss_pkg::SLV_ACTIVE) begin
      state_mem[{i_fail_port, i_fail_node}] <= mlss_pkg::SLV_SUSP;
      dly_mem[{i_fail_port, i_fail_node}]   <= i_suspend_scans;
    end
    if (wr_node) begin
      // widen before the product so block 19 still lands on command 95
      node_mem[8'(s_r.blk) * 8'(mlss_pkg::CMDS_PER_BLK) + 8'(s_r.cmd) +
               (s_r.port ? mlss_pkg::CMDS_PER_PRT : 8'h00)] <= i_wb_word[7:0];
      state_mem[{s_r.port, i_wb_word[7:0]}] <= mlss_pkg::SLV_ACTIVE;
    end
    if (wr_slv) begin
      state_mem[{s_r.port, i_wb_word[7:0]}] <= wr_val;
    end
  end
  // =====================================================================
  // read-block path buffered toward the host
  mlss_fifo #(
    .WIDTH ($bits(mlss_pkg::mlss_word_s)),
    .DEPTH (mlss_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_valid   (push),
    .i_data    (ow),
    .o_ready   (f_ready),
    .o_valid   (o_rd_valid),
    .o_data    (fw),
    .i_ready   (i_rd_ready)
  );
  assign o_rd_word    = fw.data;
  assign o_rd_last    = fw.last;
  assign o_wb_ready   = s_r.rdy;
  assign o_scan_done  = s_r.sdone;
  assign o_scan_allow = s_r.sallow;
  assign o_load_done  = s_r.ldone;
endmodule // mlss_core
`default_nettype wire

// [src/mlss_pkg.sv]
// package: block codes, table encodings and carrier types for the block engine
package mlss_pkg;

  // =====================================================================
  // block codes
  localparam logic [15:0] LIST_BASE_P1 = 16'h1770; // 6000
  localparam logic [15:0] LIST_BASE_P2 = 16'h17d4; // 6100
  localparam logic [15:0] LIST_BLOCKS  = 16'h0014; // 20 blocks per port
  localparam logic [15:0] CTL_BASE_P1  = 16'h0bb8; // 3000
  localparam logic [15:0] CTL_BASE_P2  = 16'h0c1c; // 3100
  localparam logic [15:0] OFF_ENA      = 16'h0001;
  localparam logic [15:0] OFF_STAT_LO  = 16'h0002;
  localparam logic [15:0] OFF_STAT_HI  = 16'h0006;
  localparam logic [15:0] REQ_MARK     = 16'hfffe; // -2 in word zero

  // =====================================================================
  // block geometry
  localparam logic [5:0]  LAST_WORD    = 6'h3f;
  localparam logic [5:0]  FIRST_DATA   = 6'h02;
  localparam logic [5:0]  LAST_DATA    = 6'h3d; // word 61
  localparam logic [5:0]  LAST_CMDW    = 6'h3c; // word 60
  localparam logic [3:0]  CMD_LAST_OFF = 4'hb;  // twelve words per command
  localparam logic [3:0]  CMD_NODE_OFF = 4'h0;  // node address word
  localparam logic [2:0]  CMDS_PER_BLK = 3'h5;
  localparam logic [7:0]  CMDS_PER_PRT = 8'h64; // 100
  localparam logic [8:0]  GROUP_SIZE   = 9'h03c; // 60
  localparam logic [4:0]  LAST_BLK     = 5'h13;  // 19
  localparam logic [8:0]  CLR_LAST     = 9'h1ff;
  localparam int          FIFO_DEPTH   = 16;

  // =====================================================================
  // slave states
  typedef enum logic [1:0] {
    SLV_UNDEF = 2'h0,
    SLV_ACTIVE = 2'h1,
    SLV_SUSP = 2'h2,
    SLV_DISABLED = 2'h3
  } mlss_slv_e;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_LIST = 3'h1,
    K_STAT = 3'h2,
    K_DIS  = 3'h3,
    K_ENA  = 3'h4,
    K_REQ  = 3'h5
  } mlss_kind_e;

  typedef enum logic [1:0] {
    ST_CLR  = 2'b00,
    ST_EMIT = 2'b01,
    ST_RECV = 2'b11
  } mlss_st_e;

  typedef struct packed {
    logic        last;
    logic [15:0] data;
  } mlss_word_s;

endpackage

// [verif/mlss_core_sva.sv]
// checker: port-level assertions for the block engine
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// checker module
module mlss_core_sva (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_srst,
  // restart and configuration
  input wire logic        i_restart,
  input wire logic [15:0] i_suspend_scans,
  // write blocks
  input wire logic        i_wb_valid,
  input wire logic [15:0] i_wb_word,
  input wire logic        o_wb_ready,
  // read blocks
  input wire logic        o_rd_valid,
  input wire logic [15:0] o_rd_word,
  input wire logic        o_rd_last,
  input wire logic        i_rd_ready,
  // list scan and failures
  input wire logic        i_scan_valid,
  input wire logic        i_scan_port,
  input wire logic [6:0]  i_scan_cmd,
  input wire logic        o_scan_done,
  input wire logic        o_scan_allow,
  input wire logic        i_fail_valid,
  input wire logic        i_fail_port,
  input wire logic [7:0]  i_fail_node,
  // status
  input wire logic        o_load_done
);
  logic [5:0]  widx_r;
  logic [15:0] w0_r;

  // word position in the outgoing block; wraps after word 63 by width
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      widx_r <= 6'h00;
      w0_r   <= 16'h0000;
    end else if (o_rd_valid && i_rd_ready) begin
      widx_r <= widx_r + 6'h01;
      if (widx_r == 6'h00) begin
        w0_r <= o_rd_word;
      end
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  property p_reset_quiet;
    $past(i_srst) |-> !o_rd_valid && !o_wb_ready && !o_load_done
      && !o_scan_done;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs busy right after reset");
  property p_scan_answer;
    i_scan_valid |=> o_scan_done;
  endproperty
  a_scan_answer: assert property (p_scan_answer)
    else $error("scan not answered");
  property p_scan_cause;
    o_scan_done |-> $past(i_scan_valid);
  endproperty
  a_scan_cause: assert property (p_scan_cause)
    else $error("scan answer without scan");
  property p_allow_qual;
    o_scan_allow |-> o_scan_done;
  endproperty
  a_allow_qual: assert property (p_allow_qual)
    else $error("allow outside a scan answer");
  property p_rd_hold;
    o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_word)
      && $stable(o_rd_last);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read word changed while stalled");
  property p_last_word;
    o_rd_valid |-> o_rd_last == (widx_r == 6'h3f);
  endproperty
  a_last_word: assert property (p_last_word)
    else $error("last flag not on word 63");
  property p_req_code;
    o_rd_valid && widx_r == 6'h01 && w0_r == 16'hfffe |->
      o_rd_word inside {[16'h1770:16'h1783], [16'h17d4:16'h17e7]};
  endproperty
  a_req_code: assert property (p_req_code)
    else $error("requested code outside the list ranges");
  property p_echo;
    o_rd_valid && widx_r == 6'h01 && w0_r != 16'hfffe |-> o_rd_word == w0_r;
  endproperty
  a_echo: assert property (p_echo)
    else $error("reply word one differs from word zero");
  property p_state_range;
    o_rd_valid && widx_r inside {[6'h02:6'h3d]} &&
      w0_r inside {[16'h0bba:16'h0bbe], [16'h0c1e:16'h0c22]} |->
      o_rd_word <= 16'h0003;
  endproperty
  a_state_range: assert property (p_state_range)
    else $error("slave state out of range");
  property p_no_req_loaded;
    o_load_done && o_rd_valid && widx_r == 6'h00 |-> o_rd_word != 16'hfffe;
  endproperty
  a_no_req_loaded: assert property (p_no_req_loaded)
    else $error("list request after loading");
  property p_load_keep;
    o_load_done && !i_restart |=> o_load_done;
  endproperty
  a_load_keep: assert property (p_load_keep)
    else $error("load done dropped without restart");
  property p_reply_due;
    $fell(o_wb_ready) && o_load_done |-> ##[1:4] o_rd_valid;
  endproperty
  a_reply_due: assert property (p_reply_due)
    else $error("reply did not start");

endmodule // mlss_core_sva

bind mlss_core mlss_core_sva i_mlss_core_sva (
  .i_ref_clk, .i_srst, .i_restart, .i_suspend_scans, .i_wb_valid,
  .i_wb_word, .o_wb_ready, .o_rd_valid, .o_rd_word, .o_rd_last,
  .i_rd_ready, .i_scan_valid, .i_scan_port, .i_scan_cmd, .o_scan_done,
  .o_scan_allow, .i_fail_valid, .i_fail_port, .i_fail_node, .o_load_done
);

`default_nettype wire

// [verif/mlss_host_model.sv]
// host controller model: answers list requests, collects read blocks
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// host model
module mlss_host_model (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // read blocks from the module
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_word,
  input  wire logic        i_rd_last,
  output logic             o_rd_ready,
  // write blocks to the module
  output logic             o_wb_valid,
  output logic [15:0]      o_wb_word,
  input  wire logic        i_wb_ready
);
  logic [15:0] rbuf [64];
  logic [15:0] tx   [64];
  int          rptr    = 0;
  int          nblk    = 0;
  int          nreq    = 0;
  int          seq_err = 0;
  int          cyc     = 0;
  int          base;

  initial begin
    o_wb_valid = 1'b0;
    o_wb_word  = 16'h0000;
    o_rd_ready = 1'b0;
  end

  // stall one cycle in four so the read path meets backpressure
  always @(negedge i_ref_clk) begin
    cyc++;
    o_rd_ready <= (cyc % 4) != 0;
  end

  // gather read words; the last flag closes a block
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rptr = 0;
    end else if (i_rd_valid && o_rd_ready) begin
      rbuf[rptr] = i_rd_word;
      rptr = i_rd_last ? 0 : rptr + 1;
      nblk += int'(i_rd_last);
    end
  end

  // words held until taken; the line shows the inverse once released
  task automatic send_block();
    for (int i = 0; i < 64; i++) begin
      @(negedge i_ref_clk);
      o_wb_valid = 1'b1;
      o_wb_word  = tx[i];
      do @(posedge i_ref_clk); while (i_wb_ready !== 1'b1);
    end
    @(negedge i_ref_clk);
    o_wb_valid = 1'b0;
    o_wb_word  = ~o_wb_word;
  endtask

  // every request answered with the block it names, in order
  initial forever begin
    @(posedge i_ref_clk iff (i_rd_valid && o_rd_ready && i_rd_last));
    #1;
    if (rbuf[0] === 16'hfffe) begin
      if (rbuf[1] !== ((nreq % 40 < 20) ? 16'h1770 + 16'(nreq % 40)
                       : 16'h17d4 + 16'(nreq % 40 - 20))) begin
        seq_err++;
      end
      nreq++;
      base = (rbuf[1] >= 16'h17d4) ? 100 + 5 * (rbuf[1] - 16'h17d4)
                                   : 5 * (rbuf[1] - 16'h1770);
      for (int i = 0; i < 64; i++) tx[i] = 16'h0000;
      tx[0] = rbuf[1];
      for (int k = 0; k < 5; k++) tx[1 + 12 * k] = 16'(base + k);
      send_block();
    end
  end

endmodule // mlss_host_model

`default_nettype wire

// [verif/tb_master_list_and_slave_status_blocks.sv]
// testbench: list loading, status reads, overrides, suspension, restart
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin \
  checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("BAD %0t got %0h exp %0h", $time, (a), (e)); \
  end \
end

// =====================================================================
// top
module tb_master_list_and_slave_status_blocks;
  logic        i_ref_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_restart = 1'b0;
  logic [15:0] i_suspend_scans = 16'h0003;
  logic        i_scan_valid = 1'b0;
  logic        i_scan_port = 1'b0;
  logic [6:0]  i_scan_cmd = 7'h00;
  logic        i_fail_valid = 1'b0;
  logic        i_fail_port = 1'b0;
  logic [7:0]  i_fail_node = 8'h00;
  logic        i_wb_valid, o_wb_ready, o_rd_valid, o_rd_last, i_rd_ready;
  logic        o_scan_done, o_scan_allow, o_load_done;
  logic [15:0] i_wb_word, o_rd_word;
  logic [1:0]  exp_st [2][256];
  int          miscompares = 0;
  int          checks = 0;

  always #20 i_ref_clk = ~i_ref_clk;

  mlss_core i_mlss_core (
    .i_ref_clk, .i_srst, .i_restart, .i_suspend_scans, .i_wb_valid,
    .i_wb_word, .o_wb_ready, .o_rd_valid, .o_rd_word, .o_rd_last,
    .i_rd_ready, .i_scan_valid, .i_scan_port, .i_scan_cmd, .o_scan_done,
    .o_scan_allow, .i_fail_valid, .i_fail_port, .i_fail_node, .o_load_done
  );

  mlss_host_model i_host (
    .i_ref_clk, .i_srst, .i_rd_valid(o_rd_valid), .i_rd_word(o_rd_word),
    .i_rd_last(o_rd_last), .o_rd_ready(i_rd_ready), .o_wb_valid(i_wb_valid),
    .o_wb_word(i_wb_word), .i_wb_ready(o_wb_ready)
  );

  // =====================================================================
  // shared tasks
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // loaded lists: port one holds nodes 0-99, port two nodes 100-199
  task automatic model_init();
    for (int n = 0; n < 256; n++) begin
      exp_st[0][n] = (n < 100) ? 2'h1 : 2'h0;
      exp_st[1][n] = (n >= 100 && n < 200) ? 2'h1 : 2'h0;
    end
  endtask

  // send the staged block and wait, bounded, for the answer block
  task automatic xfer();
    int n0;
    n0 = i_host.nblk;
    i_host.send_block();
    for (int t = 0; t < 600 && i_host.nblk == n0; t++) @(posedge i_ref_clk);
    #1;
    `CHK(i_host.nblk, n0 + 1)
    `CHK(i_host.rbuf[0], i_host.tx[0])
    `CHK(i_host.rbuf[1], i_host.tx[0])
  endtask

  task automatic ctl_blk(input logic [15:0] code, cnt, a, b, c, d, exp_n);
    for (int i = 0; i < 64; i++) i_host.tx[i] = 16'h0000;
    i_host.tx[0] = code;
    i_host.tx[1] = cnt;
    i_host.tx[2] = a;
    i_host.tx[3] = b;
    i_host.tx[4] = c;
    i_host.tx[5] = d;
    xfer();
    `CHK(i_host.rbuf[2], exp_n)
    `CHK(i_host.rbuf[3], 16'h0000)
  endtask

  task automatic check_stat(input logic [15:0] code);
    int p;
    int node;
    logic [15:0] ev;
    p = (code >= 16'h0c1c) ? 1 : 0;
    for (int i = 0; i < 64; i++) i_host.tx[i] = 16'h0000;
    i_host.tx[0] = code;
    xfer();
    for (int i = 2; i < 64; i++) begin
      node = 60 * (code - (p ? 3102 : 3002)) + i - 2;
      ev = (i > 61 || node > 255) ? 16'h0000 : 16'(exp_st[p][node]);
      `CHK(i_host.rbuf[i], ev)
    end
  endtask

  // every status code of both ports
  task automatic sweep();
    for (int g = 0; g < 5; g++) begin
      check_stat(16'h0bba + 16'(g));
      check_stat(16'h0c1e + 16'(g));
    end
  endtask

  task automatic scan(input logic port, input logic [6:0] cmd, input logic e);
    @(negedge i_ref_clk);
    i_scan_valid = 1'b1;
    i_scan_port = port;
    i_scan_cmd = cmd;
    @(negedge i_ref_clk);
    i_scan_valid = 1'b0;
    `CHK(o_scan_done, 1'b1)
    `CHK(o_scan_allow, e)
  endtask

  task automatic fail(input logic [7:0] node);
    @(negedge i_ref_clk);
    i_fail_valid = 1'b1;
    i_fail_port = 1'b0;
    i_fail_node = node;
    @(negedge i_ref_clk);
    i_fail_valid = 1'b0;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_load(input int n);
    for (int t = 0; t < 20000 && o_load_done !== 1'b1; t++) begin
      @(posedge i_ref_clk);
    end
    @(negedge i_ref_clk);
    `CHK(o_load_done, 1'b1)
    `CHK(i_host.nreq, n)
    `CHK(i_host.seq_err, 0)
    model_init();
  endtask

  // out-of-range index and slots past the count must not be acted on
  task automatic t_override();
    ctl_blk(16'h0bb8, 16'h4, 16'h5, 16'h12c, 16'h7, 16'hc8, 16'h3);
    exp_st[0][5] = 2'h3;
    exp_st[0][7] = 2'h3;
    exp_st[0][200] = 2'h3;
    ctl_blk(16'h0c1c, 16'h1, 16'h96, 16'h0, 16'h0, 16'h0, 16'h1);
    scan(1'b0, 7'h05, 1'b0);
    scan(1'b1, 7'h32, 1'b0);
    ctl_blk(16'h0c1d, 16'h3, 16'h96, 16'h120, 16'hfa, 16'h5, 16'h2);
    exp_st[1][250] = 2'h1;
    scan(1'b1, 7'h32, 1'b1);
  endtask

  // delay of three scans; a failure on a disabled slave changes nothing
  task automatic t_suspend();
    fail(8'h0a);
    fail(8'h05);
    exp_st[0][10] = 2'h2;
    sweep();
    scan(1'b0, 7'h0a, 1'b0);
    scan(1'b0, 7'h0a, 1'b0);
    scan(1'b0, 7'h0a, 1'b1);
    exp_st[0][10] = 2'h1;
    check_stat(16'h0bba);
  endtask

  task automatic t_restart();
    @(negedge i_ref_clk);
    i_restart = 1'b1;
    @(negedge i_ref_clk);
    i_restart = 1'b0;
    `CHK(o_load_done, 1'b0)
    t_load(80);
    sweep();
  endtask

  // main sequence: reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_srst = 1'b0;
    t_load(40);
    sweep();
    t_override();
    t_suspend();
    t_restart();
    give_verdict();
  end

  // watchdog well above the expected run of about 20000 cycles
  initial begin
    #(40 * 80000);
    miscompares++;
    give_verdict();
  end

endmodule // tb_master_list_and_slave_status_blocks

`default_nettype wire
